// ---- logic/oam_chan_ram.v ----
`timescale 1ns/10ps
`include "oam_defs.vh"

module oam_chan_ram (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst,
  // Access port
  input  wire       acc_valid,
  input  wire       acc_we,
  input  wire       acc_use_ptr,
  input  wire [7:0] acc_addr,
  input  wire [7:0] acc_wdata,
  output wire [7:0] acc_rdata,
  // Pointer load and view
  input  wire       ptr_we,
  input  wire [7:0] ptr_wdata,
  output reg  [7:0] ptr_ff
);

  reg  [7:0] mem [0:255];
  wire [7:0] sel_addr;

  // Pointer path or external address path
  assign sel_addr  = acc_use_ptr ? ptr_ff : acc_addr;
  assign acc_rdata = mem[sel_addr];

  // Storage has no reset; contents are data, not control
  always @(posedge ref_clk) begin
    if (acc_valid && acc_we) begin
      mem[sel_addr] <= acc_wdata;
    end
  end

  // Post increment lets software stream a block without reloading
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_ff <= `OAM_CHPTR_RST;
    end else if (ptr_we) begin
      ptr_ff <= ptr_wdata;
    end else if (acc_valid && acc_use_ptr) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

endmodule // oam_chan_ram

// ---- logic/oam_defs.vh ----
`ifndef OAM_DEFS_VH
`define OAM_DEFS_VH

// Request modes presented by the execution logic
`define OAM_MODE_DIRECT   4'h0
`define OAM_MODE_IND8     4'h1
`define OAM_MODE_EXT_RI   4'h2
`define OAM_MODE_EXT_DATA_POINTER_16 4'h3
`define OAM_MODE_REG      4'h4
`define OAM_MODE_BIT      4'h5
`define OAM_MODE_IDX_DATA_POINTER_16 4'h6
`define OAM_MODE_IDX_PC   4'h7
`define OAM_MODE_IMM      4'h8
`define OAM_MODE_PUSH     4'h9
`define OAM_MODE_POP      4'ha
`define OAM_MODE_SPEC     4'hb

// Pointer selects for 8-bit indirect modes
`define OAM_PTR_R0        2'h0
`define OAM_PTR_R1        2'h1
`define OAM_PTR_SP        2'h2

// Special function register byte addresses
`define OAM_SFR_SP        8'h81
`define OAM_SFR_DPL       8'h82
`define OAM_SFR_DPH       8'h83
`define OAM_SFR_CHPTR     8'h9a
`define OAM_SFR_CHDATA    8'h9b
`define OAM_SFR_XPAGE     8'ha1
`define OAM_SFR_PSW       8'hd0
`define OAM_SFR_ACC       8'he0

// Status word field positions
`define OAM_PSW_BANK_HI   4
`define OAM_PSW_BANK_LO   3

// Reset values
`define OAM_SP_RST        8'h07
`define OAM_PSW_RST       8'h00
`define OAM_ACC_RST       8'h00
`define OAM_DATA_POINTER_16_RST      16'h0000
`define OAM_XPAGE_RST     8'h00
`define OAM_CHPTR_RST     8'h00

// Map positions
`define OAM_BITRAM_BASE   8'h20
`define OAM_CHRAM_PAGE    8'hff
`define OAM_SFR_SPACE_BIT 7

`endif

// ---- logic/oam_mapper.v ----
`timescale 1ns/10ps
`include "oam_defs.vh"

// How it works
// - Channel RAM reached through pointer register then data port register.
// - Each data port access advances the channel RAM pointer.
// - Channel RAM answers external moves at FF00-FFFF via data pointer or bank pointer.
// - Channel RAM disabled means FF00-FFFF goes out to other resources.
// - Module RAM selected by the 8K window that the decode logic places.
// - Special registers reached only by direct addressing at 80h-FFh.
// - Only special registers with low digit 0h or 8h accept bit access.
// - Bit addresses 80h-FFh select bits of bit-addressable special registers.
// - Direct mode takes an 8-bit address reaching internal RAM or special registers.
// - Indirect modes take the address from a register, internal or external.
// - 8-bit indirect source is bank register zero, one, or stack pointer; external 8-bit moves refuse the stack pointer.
// - 16-bit indirect source is only the data pointer.
// - Register mode picks one of eight registers by a 3-bit field.
// - Status word bank bits choose which of four banks at execution.
// - Register-specific mode infers accumulator or data pointer from opcode alone.
// - Immediate operand read from program memory after the opcode.
// - Indexed mode only reads program memory; writes are refused.
// - Indexed address is accumulator plus data pointer or program counter.
// - Four banks of eight registers occupy internal RAM 0-31.
// - Bytes 32-47 hold bit addresses 0-127, lowest bit of byte 32 first.
// - Stack pointer increments before push and resets to 07h.
module oam_mapper (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Operand request from the execution logic
  input  wire        req_valid,
  input  wire [3:0]  req_mode,
  input  wire        req_write,
  input  wire [7:0]  req_addr,
  input  wire [1:0]  req_ptr_sel,
  input  wire [7:0]  req_wdata,
  input  wire [15:0] req_pc,
  output reg         req_ready_ff,
  // Operand answer
  output reg         rsp_valid_ff,
  output reg  [7:0]  rsp_data_ff,
  output reg         rsp_err_ff,
  // External data space
  output reg         xd_req_ff,
  output reg         xd_we_ff,
  output reg  [15:0] xd_addr_ff,
  output reg  [7:0]  xd_wdata_ff,
  output reg         mod_ram_sel_ff,
  input  wire [7:0]  xd_rdata,
  // Program memory read
  output reg         code_req_ff,
  output reg  [15:0] code_addr_ff,
  input  wire [7:0]  code_rdata,
  // Map configuration
  input  wire        chan_ram_en,
  input  wire        mod_ram_en,
  input  wire [2:0]  mod_ram_base
);

  reg  [7:0]  iram    [0:255];
  reg  [7:0]  sfr_mem [0:127];
  reg  [7:0]  sp_ff, psw_ff, acc_ff, xpage_ff;
  reg  [15:0] data_pointer_16_ff;
  reg         wait_ff, wait_code_ff;
  wire        take;
  wire [1:0]  bank;
  wire [7:0]  ch_rdata, ch_ptr;
  reg  [7:0]  ptr_val, bit_byte, bit_old;
  reg  [15:0] xa;
  // Decode outputs
  reg         iram_we, sfr_we, ch_acc, ch_we, ch_use_ptr, ch_ptr_we, sp_inc, sp_dec;
  reg         data_pointer_16_inc, ext_go, mod_hit, code_go, err;
  reg  [7:0]  iram_wa, iram_wd, sfr_wa, sfr_wd, ch_addr, ch_wd, rd;
  reg  [15:0] code_a;

  // Reads of the special register space, shared by byte and bit paths
  function [7:0] sfr_read;
    input [7:0] a;
    begin
      case (a)
        `OAM_SFR_SP:     sfr_read = sp_ff;
        `OAM_SFR_DPL:    sfr_read = data_pointer_16_ff[7:0];
        `OAM_SFR_DPH:    sfr_read = data_pointer_16_ff[15:8];
        `OAM_SFR_PSW:    sfr_read = psw_ff;
        `OAM_SFR_ACC:    sfr_read = acc_ff;
        `OAM_SFR_XPAGE:  sfr_read = xpage_ff;
        `OAM_SFR_CHPTR:  sfr_read = ch_ptr;
        `OAM_SFR_CHDATA: sfr_read = ch_rdata;
        default:         sfr_read = sfr_mem[a[6:0]];
      endcase
    end
  endfunction

  // Table lookup address; the carry ripples into the high byte
  function [15:0] idx_add;
    input [15:0] base;
    input [7:0]  ofs;
    begin
      idx_add = base + {8'h00, ofs};
    end
  endfunction

  // Handshake and active register bank
  assign take = req_valid & req_ready_ff;
  assign bank = psw_ff[`OAM_PSW_BANK_HI:`OAM_PSW_BANK_LO];
  // Address source for 8-bit indirect modes
  always @* begin
    case (req_ptr_sel)
      `OAM_PTR_R0: ptr_val = iram[{bank, 3'h0}];
      `OAM_PTR_R1: ptr_val = iram[{bank, 3'h1}];
      default:     ptr_val = sp_ff;
    endcase
  end

  // External address and bit location
  always @* begin
    xa = (req_mode == `OAM_MODE_EXT_DATA_POINTER_16) ? data_pointer_16_ff : {xpage_ff, ptr_val};
    if (req_addr[7]) begin
      bit_byte = {req_addr[7:3], 3'h0};
      bit_old  = sfr_read({req_addr[7:3], 3'h0});
    end else begin
      bit_byte = `OAM_BITRAM_BASE + {4'h0, req_addr[6:3]};
      bit_old  = iram[`OAM_BITRAM_BASE + {4'h0, req_addr[6:3]}];
    end
  end

  // Request decode; one access per accepted request
  always @* begin
    iram_we    = 1'b0;
    iram_wa    = 8'h00;
    iram_wd    = req_wdata;
    sfr_we     = 1'b0;
    sfr_wa     = req_addr;
    sfr_wd     = req_wdata;
    ch_acc     = 1'b0;
    ch_we      = 1'b0;
    ch_use_ptr = 1'b0;
    ch_addr    = xa[7:0];
    ch_wd      = req_wdata;
    ch_ptr_we  = 1'b0;
    sp_inc     = 1'b0;
    sp_dec     = 1'b0;
    data_pointer_16_inc   = 1'b0;
    ext_go     = 1'b0;
    mod_hit    = mod_ram_en & (xa[15:13] == mod_ram_base);
    code_go    = 1'b0;
    code_a     = req_pc;
    rd         = 8'h00;
    err        = 1'b0;
    if (take) begin
      case (req_mode)
        `OAM_MODE_DIRECT: begin
          if (req_addr[`OAM_SFR_SPACE_BIT]) begin
            if (req_addr == `OAM_SFR_CHDATA) begin
              ch_acc     = 1'b1;
              ch_use_ptr = 1'b1;
              ch_we      = req_write;
              rd         = ch_rdata;
            end else if (req_write && req_addr == `OAM_SFR_CHPTR) begin
              ch_ptr_we  = 1'b1;
            end else begin
              rd         = sfr_read(req_addr);
              sfr_we     = req_write;
            end
          end else begin
            rd      = iram[req_addr];
            iram_we = req_write;
            iram_wa = req_addr;
          end
        end
        `OAM_MODE_IND8: begin
          err     = (req_ptr_sel == 2'h3);
          rd      = iram[ptr_val];
          iram_we = req_write & ~err;
          iram_wa = ptr_val;
        end
        `OAM_MODE_EXT_RI, `OAM_MODE_EXT_DATA_POINTER_16: begin
          if (req_mode == `OAM_MODE_EXT_RI && req_ptr_sel > `OAM_PTR_R1) begin
            err    = 1'b1;
          end else if (chan_ram_en && xa[15:8] == `OAM_CHRAM_PAGE) begin
            ch_acc = 1'b1;
            ch_we  = req_write;
            rd     = ch_rdata;
          end else begin
            ext_go = 1'b1;
          end
        end
        `OAM_MODE_REG: begin
          rd      = iram[{bank, req_addr[2:0]}];
          iram_we = req_write;
          iram_wa = {bank, req_addr[2:0]};
        end
        `OAM_MODE_BIT: begin
          rd = {7'h00, bit_old[req_addr[2:0]]};
          if (req_write) begin
            if (req_addr[7]) begin
              sfr_we  = 1'b1;
              sfr_wa  = bit_byte;
              sfr_wd  = bit_old;
              sfr_wd[req_addr[2:0]] = req_wdata[0];
            end else begin
              iram_we = 1'b1;
              iram_wa = bit_byte;
              iram_wd = bit_old;
              iram_wd[req_addr[2:0]] = req_wdata[0];
            end
          end
        end
        `OAM_MODE_IDX_DATA_POINTER_16, `OAM_MODE_IDX_PC: begin
          err     = req_write;
          code_go = ~req_write;
          code_a  = idx_add((req_mode == `OAM_MODE_IDX_PC) ? req_pc : data_pointer_16_ff, acc_ff);
        end
        `OAM_MODE_IMM: begin
          code_go = ~req_write;
          err     = req_write;
        end
        `OAM_MODE_PUSH: begin
          iram_we = 1'b1;
          iram_wa = sp_ff + 8'h01;
          sp_inc  = 1'b1;
        end
        `OAM_MODE_POP: begin
          rd      = iram[sp_ff];
          sp_dec  = 1'b1;
        end
        `OAM_MODE_SPEC: begin
          if (req_addr[0]) begin
            data_pointer_16_inc = 1'b1;
            rd       = data_pointer_16_ff[7:0];
          end else begin
            rd       = acc_ff;
            sfr_we   = req_write;
            sfr_wa   = `OAM_SFR_ACC;
          end
        end
        default: err = 1'b1;
      endcase
    end
  end

  // Data storage, no reset
  always @(posedge ref_clk) begin
    if (iram_we) iram[iram_wa] <= iram_wd;
    if (sfr_we) sfr_mem[sfr_wa[6:0]] <= sfr_wd;
  end

  // Core registers held outside the storage array
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sp_ff    <= `OAM_SP_RST;
      psw_ff   <= `OAM_PSW_RST;
      acc_ff   <= `OAM_ACC_RST;
      data_pointer_16_ff  <= `OAM_DATA_POINTER_16_RST;
      xpage_ff <= `OAM_XPAGE_RST;
    end else begin
      if (sfr_we) begin
        case (sfr_wa)
          `OAM_SFR_SP:    sp_ff         <= sfr_wd;
          `OAM_SFR_DPL:   data_pointer_16_ff[7:0]  <= sfr_wd;
          `OAM_SFR_DPH:   data_pointer_16_ff[15:8] <= sfr_wd;
          `OAM_SFR_PSW:   psw_ff        <= sfr_wd;
          `OAM_SFR_ACC:   acc_ff        <= sfr_wd;
          `OAM_SFR_XPAGE: xpage_ff      <= sfr_wd;
          default:        xpage_ff      <= xpage_ff;
        endcase
      end
      if (sp_inc) sp_ff <= sp_ff + 8'h01;
      else if (sp_dec) sp_ff <= sp_ff - 8'h01;
      if (data_pointer_16_inc) data_pointer_16_ff <= data_pointer_16_ff + 16'h0001;
    end
  end

  // Answer sequencing; external and code reads take one extra cycle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_ready_ff   <= 1'b1;
      rsp_valid_ff   <= 1'b0;
      rsp_data_ff    <= 8'h00;
      rsp_err_ff     <= 1'b0;
      xd_req_ff      <= 1'b0;
      xd_we_ff       <= 1'b0;
      xd_addr_ff     <= 16'h0000;
      xd_wdata_ff    <= 8'h00;
      mod_ram_sel_ff <= 1'b0;
      code_req_ff    <= 1'b0;
      code_addr_ff   <= 16'h0000;
      wait_ff        <= 1'b0;
      wait_code_ff   <= 1'b0;
    end else begin
      rsp_valid_ff <= 1'b0;
      xd_req_ff    <= 1'b0;
      code_req_ff  <= 1'b0;
      if (wait_ff) begin
        wait_ff      <= 1'b0;
        req_ready_ff <= 1'b1;
        rsp_valid_ff <= 1'b1;
        rsp_err_ff   <= 1'b0;
        if (wait_code_ff) rsp_data_ff <= code_rdata;
        else rsp_data_ff <= xd_we_ff ? 8'h00 : xd_rdata;
      end else if (take) begin
        if (ext_go || code_go) begin
          wait_ff      <= 1'b1;
          wait_code_ff <= code_go;
          req_ready_ff <= 1'b0;
          xd_req_ff    <= ext_go;
          code_req_ff  <= code_go;
        end else begin
          rsp_valid_ff <= 1'b1;
          rsp_data_ff  <= rd;
          rsp_err_ff   <= err;
        end
        if (ext_go) begin
          xd_we_ff       <= req_write;
          xd_addr_ff     <= xa;
          xd_wdata_ff    <= req_wdata;
          mod_ram_sel_ff <= mod_hit;
        end
        if (code_go) code_addr_ff <= code_a;
      end
    end
  end

  oam_chan_ram u_chan_ram (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .acc_valid   (ch_acc),
    .acc_we      (ch_we),
    .acc_use_ptr (ch_use_ptr),
    .acc_addr    (ch_addr),
    .acc_wdata   (ch_wd),
    .acc_rdata   (ch_rdata),
    .ptr_we      (ch_ptr_we),
    .ptr_wdata   (req_wdata),
    .ptr_ff      (ch_ptr)
  );

endmodule // oam_mapper

// ---- sim/oam_mapper_bench.sv ----
`timescale 1ns/10ps
`include "oam_defs.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end

module oam_mapper_bench;
  reg         ref_clk, rst, req_valid, req_write, chan_ram_en, mod_ram_en, er;
  reg  [3:0]  req_mode;
  reg  [7:0]  req_addr, req_wdata, rd;
  reg  [1:0]  req_ptr_sel;
  reg  [15:0] req_pc;
  reg  [2:0]  mod_ram_base;
  wire        req_ready_ff, rsp_valid_ff, rsp_err_ff, xd_req_ff, xd_we_ff, mod_ram_sel_ff, code_req_ff;
  wire [7:0]  rsp_data_ff, xd_wdata_ff, xd_rdata, code_rdata;
  wire [15:0] xd_addr_ff, code_addr_ff;
  integer     num_errors = 0, checked = 0, xd_cnt = 0, i, k;

  oam_mapper u_dut (
    .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_mode(req_mode), .req_write(req_write),
    .req_addr(req_addr), .req_ptr_sel(req_ptr_sel), .req_wdata(req_wdata), .req_pc(req_pc),
    .req_ready_ff(req_ready_ff), .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff),
    .rsp_err_ff(rsp_err_ff), .xd_req_ff(xd_req_ff), .xd_we_ff(xd_we_ff), .xd_addr_ff(xd_addr_ff),
    .xd_wdata_ff(xd_wdata_ff), .mod_ram_sel_ff(mod_ram_sel_ff), .xd_rdata(xd_rdata),
    .code_req_ff(code_req_ff), .code_addr_ff(code_addr_ff), .code_rdata(code_rdata),
    .chan_ram_en(chan_ram_en), .mod_ram_en(mod_ram_en), .mod_ram_base(mod_ram_base));

  oam_mem_model u_mem (
    .ref_clk(ref_clk), .xd_req_ff(xd_req_ff), .xd_addr_ff(xd_addr_ff), .xd_rdata(xd_rdata),
    .code_req_ff(code_req_ff), .code_addr_ff(code_addr_ff), .code_rdata(code_rdata));

  // Clock and external access count
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (xd_req_ff) xd_cnt++;
  end

  task conclude;
    begin
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask

  // One request, then a bounded wait for its answer
  task op(input [3:0] m, input w, input [7:0] a, input [1:0] p, input [7:0] d);
    integer n;
    begin
      @(negedge ref_clk);
      req_valid = 1;
      req_mode = m;
      req_write = w;
      req_addr = a;
      req_ptr_sel = p;
      req_wdata = d;
      @(negedge ref_clk);
      req_valid = 0;
      n = 0;
      while (rsp_valid_ff !== 1'b1 && n < 4) begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 4) begin
        $display("CHECK FAILED %0t answer timeout", $time);
        num_errors++;
        conclude;
      end
      rd = rsp_data_ff;
      er = rsp_err_ff;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    op(`OAM_MODE_DIRECT, 1'b1, a, 2'h0, d);
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      op(`OAM_MODE_DIRECT, 1'b0, a, 2'h0, 8'h00);
      `CHK(rd, e);
    end
  endtask

  task t_stack;
    begin
      rdc(`OAM_SFR_SP, 8'h07);
      op(`OAM_MODE_PUSH, 1'b1, 8'h00, 2'h0, 8'h77);
      rdc(8'h08, 8'h77);
      rdc(`OAM_SFR_SP, 8'h08);
      op(`OAM_MODE_POP, 1'b0, 8'h00, 2'h0, 8'h00);
      `CHK({er, rd}, {1'b0, 8'h77});
    end
  endtask

  // Each bank in turn, so a stuck bank select shows
  task t_banks;
    begin
      for (k = 0; k < 4; k++) begin
        wr(`OAM_SFR_PSW, 8'(k << `OAM_PSW_BANK_LO));
        op(`OAM_MODE_REG, 1'b1, 8'(k + 1), 2'h0, 8'(8'h40 + k));
        rdc(8'(k * 9 + 1), 8'(8'h40 + k));
      end
      wr(`OAM_SFR_PSW, 8'h00);
    end
  endtask

  task t_indirect;
    begin
      wr(8'h00, 8'h90);
      wr(8'h90, 8'h33);
      op(`OAM_MODE_IND8, 1'b1, 8'h00, `OAM_PTR_R0, 8'h5c);
      rdc(8'h90, 8'h33);
      op(`OAM_MODE_IND8, 1'b0, 8'h00, `OAM_PTR_R0, 8'h00);
      `CHK(rd, 8'h5c);
      wr(8'h01, 8'h90);
      op(`OAM_MODE_IND8, 1'b0, 8'h00, `OAM_PTR_R1, 8'h00);
      `CHK(rd, 8'h5c);
      op(`OAM_MODE_IND8, 1'b1, 8'h00, `OAM_PTR_SP, 8'h4e);
      rdc(8'h07, 8'h4e);
      op(`OAM_MODE_IND8, 1'b0, 8'h00, 2'h3, 8'h00);
      `CHK(er, 1'b1);
      op(`OAM_MODE_EXT_RI, 1'b0, 8'h00, `OAM_PTR_SP, 8'h00);
      `CHK(er, 1'b1);
    end
  endtask

  task t_bits;
    begin
      wr(8'h21, 8'h00);
      op(`OAM_MODE_BIT, 1'b1, 8'h0a, 2'h0, 8'h01);
      rdc(8'h21, 8'h04);
      wr(8'ha0, 8'h00);
      op(`OAM_MODE_BIT, 1'b1, 8'ha5, 2'h0, 8'h01);
      rdc(8'ha0, 8'h20);
      op(`OAM_MODE_BIT, 1'b0, 8'h0a, 2'h0, 8'h00);
      `CHK(rd, 8'h01);
    end
  endtask

  // Pointer runs across the top of the 256 bytes
  task t_chan;
    begin
      chan_ram_en = 1;
      wr(`OAM_SFR_CHPTR, 8'hfe);
      wr(`OAM_SFR_CHDATA, 8'h11);
      wr(`OAM_SFR_CHDATA, 8'h22);
      rdc(`OAM_SFR_CHPTR, 8'h00);
      wr(`OAM_SFR_DPH, 8'hff);
      wr(`OAM_SFR_DPL, 8'hfe);
      i = xd_cnt;
      op(`OAM_MODE_EXT_DATA_POINTER_16, 1'b0, 8'h00, 2'h0, 8'h00);
      `CHK(rd, 8'h11);
      wr(`OAM_SFR_XPAGE, 8'hff);
      wr(8'h00, 8'hff);
      op(`OAM_MODE_EXT_RI, 1'b0, 8'h00, `OAM_PTR_R0, 8'h00);
      `CHK(rd, 8'h22);
      `CHK(xd_cnt, i);
      chan_ram_en = 0;
      op(`OAM_MODE_EXT_DATA_POINTER_16, 1'b0, 8'h00, 2'h0, 8'h00);
      `CHK(xd_addr_ff, 16'hfffe);
      `CHK(rd, 8'h01);
    end
  endtask

  task t_module;
    begin
      mod_ram_en = 1;
      mod_ram_base = 3'h2;
      wr(`OAM_SFR_DPH, 8'h41);
      wr(`OAM_SFR_DPL, 8'h23);
      op(`OAM_MODE_EXT_DATA_POINTER_16, 1'b1, 8'h00, 2'h0, 8'h6b);
      `CHK({xd_we_ff, mod_ram_sel_ff, xd_wdata_ff, xd_addr_ff}, {2'b11, 8'h6b, 16'h4123});
      op(`OAM_MODE_SPEC, 1'b0, 8'h01, 2'h0, 8'h00);
      `CHK(rd, 8'h23);
      // Channel RAM on, yet a page other than its own must still go out
      chan_ram_en = 1;
      mod_ram_base = 3'h3;
      op(`OAM_MODE_EXT_DATA_POINTER_16, 1'b0, 8'h00, 2'h0, 8'h00);
      `CHK({mod_ram_sel_ff, xd_addr_ff}, {1'b0, 16'h4124});
      `CHK(rd, 8'h65);
      wr(`OAM_SFR_ACC, 8'h05);
      op(`OAM_MODE_SPEC, 1'b0, 8'h00, 2'h0, 8'h00);
      `CHK(rd, 8'h05);
    end
  endtask

  // Table reads; base 10fe makes the sum carry into the high byte
  task t_code;
    begin
      req_pc = 16'h1234;
      op(`OAM_MODE_IMM, 1'b0, 8'h00, 2'h0, 8'h00);
      `CHK({code_addr_ff, rd}, {16'h1234, 8'h08});
      req_pc = 16'h10fe;
      op(`OAM_MODE_IDX_PC, 1'b0, 8'h00, 2'h0, 8'h00);
      `CHK(code_addr_ff, 16'h1103);
      op(`OAM_MODE_IDX_DATA_POINTER_16, 1'b0, 8'h00, 2'h0, 8'h00);
      `CHK(code_addr_ff, 16'h4129);
      op(`OAM_MODE_IDX_DATA_POINTER_16, 1'b1, 8'h00, 2'h0, 8'h99);
      `CHK(er, 1'b1);
      op(`OAM_MODE_IMM, 1'b1, 8'h00, 2'h0, 8'h55);
      `CHK(er, 1'b1);
    end
  endtask

  // Inputs quiet at time zero, reset for ten cycles
  initial begin
    {rst, req_valid, req_write, chan_ram_en, mod_ram_en} = 5'b10000;
    {req_mode, req_addr, req_wdata, req_ptr_sel, req_pc, mod_ram_base} = 0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 0;
    t_stack;
    t_banks;
    t_indirect;
    t_bits;
    t_chan;
    t_module;
    t_code;
    conclude;
  end
endmodule // oam_mapper_bench

// ---- sim/oam_mapper_sva.sv ----
`timescale 1ns/10ps
`include "oam_defs.vh"

module oam_mapper_sva (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Request and answer
  input wire        req_valid,
  input wire [3:0]  req_mode,
  input wire        req_write,
  input wire [1:0]  req_ptr_sel,
  input wire [7:0]  req_wdata,
  input wire [15:0] req_pc,
  input wire        req_ready_ff,
  input wire        rsp_valid_ff,
  input wire        rsp_err_ff,
  // Memory sides and map
  input wire        xd_req_ff,
  input wire        xd_we_ff,
  input wire [15:0] xd_addr_ff,
  input wire [7:0]  xd_wdata_ff,
  input wire        mod_ram_sel_ff,
  input wire        code_req_ff,
  input wire [15:0] code_addr_ff,
  input wire        chan_ram_en,
  input wire        mod_ram_en,
  input wire [2:0]  mod_ram_base
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Request classes
  wire take  = req_valid && req_ready_ff;
  wire imode = req_mode inside {`OAM_MODE_DIRECT, `OAM_MODE_IND8, `OAM_MODE_REG, `OAM_MODE_BIT,
                                `OAM_MODE_PUSH, `OAM_MODE_POP, `OAM_MODE_SPEC};
  wire xmode = req_mode == `OAM_MODE_EXT_DATA_POINTER_16 || (req_mode == `OAM_MODE_EXT_RI && !req_ptr_sel[1]);
  wire cmode = req_mode inside {`OAM_MODE_IMM, `OAM_MODE_IDX_PC, `OAM_MODE_IDX_DATA_POINTER_16};

  property p_int_answer;
    take && imode |=> rsp_valid_ff && !xd_req_ff && !code_req_ff;
  endproperty
  a_int_answer: assert property (p_int_answer) else $error("internal answer late");
  property p_ext_walk;
    take && xmode && !chan_ram_en |=> xd_req_ff && !req_ready_ff ##1 rsp_valid_ff && req_ready_ff;
  endproperty
  a_ext_walk: assert property (p_ext_walk) else $error("external walk broken");
  property p_ext_write;
    take && xmode && req_write && !chan_ram_en |=> xd_we_ff && xd_wdata_ff == $past(req_wdata);
  endproperty
  a_ext_write: assert property (p_ext_write) else $error("external write data");
  property p_chan_owns;
    xd_req_ff && $past(chan_ram_en) |-> xd_addr_ff[15:8] != `OAM_CHRAM_PAGE;
  endproperty
  a_chan_owns: assert property (p_chan_owns) else $error("channel page went out");
  property p_mod_sel;
    xd_req_ff |-> mod_ram_sel_ff == ($past(mod_ram_en) && xd_addr_ff[15:13] == $past(mod_ram_base));
  endproperty
  a_mod_sel: assert property (p_mod_sel) else $error("module select wrong");
  property p_code_walk;
    take && cmode && !req_write |=> code_req_ff && !req_ready_ff ##1 rsp_valid_ff && !rsp_err_ff;
  endproperty
  a_code_walk: assert property (p_code_walk) else $error("code read walk broken");
  property p_imm_addr;
    take && req_mode == `OAM_MODE_IMM && !req_write |=> code_addr_ff == $past(req_pc);
  endproperty
  a_imm_addr: assert property (p_imm_addr) else $error("immediate address");
  property p_idx_refuse;
    take && cmode && req_write |=> rsp_valid_ff && rsp_err_ff && !code_req_ff && !xd_req_ff;
  endproperty
  a_idx_refuse: assert property (p_idx_refuse) else $error("code write not refused");
  property p_bad_ptr;
    take && ((req_mode == `OAM_MODE_IND8 && req_ptr_sel == 2'h3) ||
             (req_mode == `OAM_MODE_EXT_RI && req_ptr_sel[1])) |=> rsp_valid_ff && rsp_err_ff && !xd_req_ff;
  endproperty
  a_bad_ptr: assert property (p_bad_ptr) else $error("bad pointer accepted");

  c_ext: cover property (take && xmode);
  c_code: cover property (take && cmode && !req_write);
  c_refuse: cover property (rsp_valid_ff && rsp_err_ff);
endmodule // oam_mapper_sva

bind oam_mapper oam_mapper_sva u_sva (
  .ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req_mode(req_mode), .req_write(req_write),
  .req_ptr_sel(req_ptr_sel), .req_wdata(req_wdata), .req_pc(req_pc), .req_ready_ff(req_ready_ff),
  .rsp_valid_ff(rsp_valid_ff), .rsp_err_ff(rsp_err_ff), .xd_req_ff(xd_req_ff), .xd_we_ff(xd_we_ff),
  .xd_addr_ff(xd_addr_ff), .xd_wdata_ff(xd_wdata_ff), .mod_ram_sel_ff(mod_ram_sel_ff),
  .code_req_ff(code_req_ff), .code_addr_ff(code_addr_ff), .chan_ram_en(chan_ram_en),
  .mod_ram_en(mod_ram_en), .mod_ram_base(mod_ram_base));

// ---- sim/oam_mem_model.sv ----
`timescale 1ns/10ps

module oam_mem_model (
  // Clock
  input  wire        ref_clk,
  // External data side
  input  wire        xd_req_ff,
  input  wire [15:0] xd_addr_ff,
  output wire [7:0]  xd_rdata,
  // Program memory side
  input  wire        code_req_ff,
  input  wire [15:0] code_addr_ff,
  output wire [7:0]  code_rdata
);
  reg [7:0] junk_ff = 8'h5a;

  // Idle value flips every cycle so a mistimed sample never matches by luck
  always @(posedge ref_clk) begin
    junk_ff <= ~junk_ff;
  end

  // Contents are a fixed function of the address; writes are taken and dropped
  assign xd_rdata   = xd_req_ff ? (xd_addr_ff[7:0] ^ xd_addr_ff[15:8]) : junk_ff;
  assign code_rdata = code_req_ff ? (code_addr_ff[7:0] ^ 8'h3c) : ~junk_ff;
endmodule // oam_mem_model
